// ==== verilog/dpt_pkg.sv ====
// shared constants for the dual pulse-width timer
package dpt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int CNT_W = 10; // counter, period and duty width
  localparam int ADDR_W = 4; // register address width
  localparam int DATA_W = 16; // register data width
  localparam int PSC_W = 6; // prescaler count width, holds up to 63
  localparam int PHASE_W = 2; // sub-step phase, four ticks per step

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (word index on the plain port)
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0; // pulse_timer_control
  localparam logic [ADDR_W-1:0] OFS_PERIOD1 = 4'h1; // period_value, channel 1
  localparam logic [ADDR_W-1:0] OFS_DUTY1 = 4'h2; // duty_buffer, channel 1
  localparam logic [ADDR_W-1:0] OFS_PERIOD2 = 4'h3; // period_value, channel 2
  localparam logic [ADDR_W-1:0] OFS_DUTY2 = 4'h4; // duty_buffer, channel 2
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h5; // sticky flags, read only
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 4'h6; // write one to clear
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h7; // interrupt enables

  ////////////////////////////////////////////////////////////////////////////
  // control register field positions
  localparam int CTL_PSC1_LSB = 0; // prescale1_low / prescale1_high
  localparam int CTL_PSC2_LSB = 2; // prescale2_low / prescale2_high
  localparam int CTL_CNT_EN_LSB = 4; // counter1_enable, counter2_enable at +1
  localparam int CTL_OUT_EN_LSB = 6; // output1_enable, output2_enable at +1
  localparam int CTL_W = 8; // control register width

  // status / clear / enable layout
  localparam int IRQ_CH1_BIT = 0; // period_irq_flag of channel 1
  localparam int IRQ_CH2_BIT = 1; // period_irq_flag of channel 2
  localparam int IRQ_W = 2; // number of flags

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [CTL_W-1:0] RST_CONTROL = 8'h00;
  localparam logic [CNT_W-1:0] RST_PERIOD = 10'h000;
  localparam logic [CNT_W-1:0] RST_DUTY = 10'h000;
  localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // prescale select codes and their last count (ratio minus one)
  localparam logic [1:0] PSC_DIV2 = 2'h0;
  localparam logic [1:0] PSC_DIV8 = 2'h1;
  localparam logic [1:0] PSC_DIV32 = 2'h2;
  localparam logic [1:0] PSC_DIV64 = 2'h3;
  localparam logic [PSC_W-1:0] PSC_LAST2 = 6'h01;
  localparam logic [PSC_W-1:0] PSC_LAST8 = 6'h07;
  localparam logic [PSC_W-1:0] PSC_LAST32 = 6'h1f;
  localparam logic [PSC_W-1:0] PSC_LAST64 = 6'h3f;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3; // fourth tick ends a step

endpackage

// ==== verilog/dpt_channel.sv ====
// one pulse-width channel: prescaler, up-counter, duty latch and comparators
`timescale 1ns/1ns
module dpt_channel #(
  parameter int CNT_W = 10
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic counter_enable,
  input wire logic [1:0] prescale_sel,
  input wire logic output_enable,
  input wire logic [CNT_W-1:0] period_value,
  input wire logic [CNT_W-1:0] duty_buffer,
  output logic pulse_r,
  output logic match_r
);

  ////////////////////////////////////////////////////////////////////////////
  // decode of the prescale selection into its last count
  function automatic logic [dpt_pkg::PSC_W-1:0] psc_last(input logic [1:0] sel);
    case (sel)
      dpt_pkg::PSC_DIV2: psc_last = dpt_pkg::PSC_LAST2;
      dpt_pkg::PSC_DIV8: psc_last = dpt_pkg::PSC_LAST8;
      dpt_pkg::PSC_DIV32: psc_last = dpt_pkg::PSC_LAST32;
      default: psc_last = dpt_pkg::PSC_LAST64;
    endcase
  endfunction

  logic [dpt_pkg::PSC_W-1:0] psc_r; // prescaler count
  logic [dpt_pkg::PHASE_W-1:0] phase_r; // tick within one increment cycle
  logic [CNT_W-1:0] period_counter_r; // time base
  logic [CNT_W-1:0] duty_latch_r; // compare value for this period

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire tick = counter_enable && (psc_r == psc_last(prescale_sel));
  wire step = tick && (phase_r == dpt_pkg::PHASE_LAST); // one increment cycle
  wire period_hit = (period_counter_r == period_value);
  wire wrap = step && period_hit;
  // fine position counts prescaled ticks, so high time is duty ticks long
  wire [CNT_W+1:0] fine_pos = {period_counter_r, phase_r};
  // look one tick ahead, so the pin drops on the edge that reaches the duty count
  wire [CNT_W+1:0] fine_nxt = fine_pos + {{CNT_W{1'b0}}, 2'b01};
  wire duty_hit = tick && (fine_nxt == {2'b00, duty_latch_r});
  wire [dpt_pkg::PSC_W-1:0] psc_nxt = tick ? '0 : psc_r + 6'h01;
  wire [CNT_W-1:0] cnt_nxt = period_hit ? '0 : period_counter_r + 10'h001;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler, holds while the counter is off to save power
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      psc_r <= '0;
    end else if (counter_enable) begin
      psc_r <= psc_nxt;
    end
  end

  // phase: four ticks make one counter increment
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase_r <= '0;
    end else if (tick) begin
      phase_r <= phase_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ten-bit up-counter, cleared on the increment after a period match
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      period_counter_r <= '0;
    end else if (step) begin
      period_counter_r <= cnt_nxt;
    end
  end

  // duty latch only moves at a period boundary, never mid-period
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      duty_latch_r <= '0;
    end else if (wrap) begin
      duty_latch_r <= duty_buffer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse output: set at period start, cleared on duty match
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pulse_r <= 1'b0;
    end else if (!output_enable) begin
      pulse_r <= 1'b0; // timer-only use keeps the pin low
    end else if (wrap) begin
      pulse_r <= (duty_buffer != '0);
    end else if (duty_hit) begin
      pulse_r <= 1'b0;
    end
  end

  // one-cycle event, same edge as the counter clear and pin change
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      match_r <= 1'b0;
    end else begin
      match_r <= wrap;
    end
  end

endmodule

// ==== verilog/dpt_top.sv ====
// dual pulse-width timer: register port, interrupt logic, two channels
`timescale 1ns/1ns
module dpt_top #(
  parameter int CNT_W = dpt_pkg::CNT_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [dpt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dpt_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dpt_pkg::DATA_W-1:0] reg_rdata,
  output logic pulse_output_pin1,
  output logic pulse_output_pin2,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  // pulse_timer_control: enables and prescale selects
  logic [dpt_pkg::CTL_W-1:0] control_r;

  // period_value per channel
  logic [CNT_W-1:0] period_r [2];

  // duty_buffer per channel, software side copy
  logic [CNT_W-1:0] duty_r [2];

  // sticky period flags and their enables
  logic [dpt_pkg::IRQ_W-1:0] irq_status_r;
  logic [dpt_pkg::IRQ_W-1:0] irq_status_nxt;
  logic [dpt_pkg::IRQ_W-1:0] irq_enable_r;

  // registered read data and interrupt line
  logic [dpt_pkg::DATA_W-1:0] rdata_r;
  logic irq_r;

  // per-channel results from the channel instances
  logic [1:0] pulse_w;
  logic [1:0] match_w;

  ////////////////////////////////////////////////////////////////////////////
  // address decode for the write strobes; the read path decodes reg_addr in its own case
  function automatic logic hit(input logic [dpt_pkg::ADDR_W-1:0] a,
                               input logic [dpt_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // write strobes per register
  wire wr_control = reg_wr && hit(reg_addr, dpt_pkg::OFS_CONTROL);
  wire wr_period1 = reg_wr && hit(reg_addr, dpt_pkg::OFS_PERIOD1);
  wire wr_duty1 = reg_wr && hit(reg_addr, dpt_pkg::OFS_DUTY1);
  wire wr_period2 = reg_wr && hit(reg_addr, dpt_pkg::OFS_PERIOD2);
  wire wr_duty2 = reg_wr && hit(reg_addr, dpt_pkg::OFS_DUTY2);
  wire wr_clear = reg_wr && hit(reg_addr, dpt_pkg::OFS_IRQ_CLEAR);
  wire wr_enable = reg_wr && hit(reg_addr, dpt_pkg::OFS_IRQ_ENABLE);

  // write data cut to register widths
  wire [dpt_pkg::CTL_W-1:0] wdata_ctl = reg_wdata[dpt_pkg::CTL_W-1:0];
  wire [CNT_W-1:0] wdata_cnt = reg_wdata[CNT_W-1:0];
  wire [dpt_pkg::IRQ_W-1:0] wdata_irq = reg_wdata[dpt_pkg::IRQ_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // control field decode
  // bit 7..0: out2 en, out1 en, cnt2 en, cnt1 en, psc2 pair, psc1 pair
  wire [1:0] cnt_en_w = control_r[dpt_pkg::CTL_CNT_EN_LSB +: 2];
  wire [1:0] out_en_w = control_r[dpt_pkg::CTL_OUT_EN_LSB +: 2];
  wire [1:0] psc1_w = control_r[dpt_pkg::CTL_PSC1_LSB +: 2];
  wire [1:0] psc2_w = control_r[dpt_pkg::CTL_PSC2_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer; unmapped and write-only addresses read zero
  logic [dpt_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      dpt_pkg::OFS_CONTROL: begin
        rd_mux[dpt_pkg::CTL_W-1:0] = control_r;
      end
      dpt_pkg::OFS_PERIOD1: begin
        rd_mux[CNT_W-1:0] = period_r[0];
      end
      dpt_pkg::OFS_DUTY1: begin
        rd_mux[CNT_W-1:0] = duty_r[0];
      end
      dpt_pkg::OFS_PERIOD2: begin
        rd_mux[CNT_W-1:0] = period_r[1];
      end
      dpt_pkg::OFS_DUTY2: begin
        rd_mux[CNT_W-1:0] = duty_r[1];
      end
      dpt_pkg::OFS_IRQ_STATUS: begin
        rd_mux[dpt_pkg::IRQ_W-1:0] = irq_status_r;
      end
      dpt_pkg::OFS_IRQ_ENABLE: begin
        rd_mux[dpt_pkg::IRQ_W-1:0] = irq_enable_r;
      end
      default: begin
        rd_mux = '0; // clear register and holes read as zero
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flag update: a match in the clear cycle still sets the flag
  always_comb begin
    irq_status_nxt = irq_status_r;
    if (wr_clear) begin
      irq_status_nxt = irq_status_r & ~wdata_irq;
    end
    irq_status_nxt = irq_status_nxt | match_w;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register, steers counters, prescalers and pins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      control_r <= dpt_pkg::RST_CONTROL;
    end else if (wr_control) begin
      control_r <= wdata_ctl;
    end
  end

  // channel 1 period and duty buffer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      period_r[0] <= dpt_pkg::RST_PERIOD;
      duty_r[0] <= dpt_pkg::RST_DUTY;
    end else begin
      if (wr_period1) begin
        period_r[0] <= wdata_cnt;
      end
      if (wr_duty1) begin
        duty_r[0] <= wdata_cnt;
      end
    end
  end

  // channel 2 period and duty buffer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      period_r[1] <= dpt_pkg::RST_PERIOD;
      duty_r[1] <= dpt_pkg::RST_DUTY;
    end else begin
      if (wr_period2) begin
        period_r[1] <= wdata_cnt;
      end
      if (wr_duty2) begin
        duty_r[1] <= wdata_cnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and enable
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_status_r <= dpt_pkg::RST_IRQ;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // enables gate the flags onto the line
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_enable_r <= dpt_pkg::RST_IRQ;
    end else if (wr_enable) begin
      irq_enable_r <= wdata_irq;
    end
  end

  // level line, one cycle behind the flag so it comes from a flop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_status_r & irq_enable_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two identical channels
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      // each channel picks its own prescale pair
      wire [1:0] psc_sel = (ch == 0) ? psc1_w : psc2_w;
      dpt_channel #(
        .CNT_W(CNT_W)
      ) u_chan (
        .clk_sys(clk_sys),
        .reset(reset),
        .counter_enable(cnt_en_w[ch]),
        .prescale_sel(psc_sel),
        .output_enable(out_en_w[ch]),
        .period_value(period_r[ch]),
        .duty_buffer(duty_r[ch]),
        .pulse_r(pulse_w[ch]),
        .match_r(match_w[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // outputs: all come straight from flops
  // pulse pins are the channel flops themselves, so no added delay
  assign pulse_output_pin1 = pulse_w[0];
  assign pulse_output_pin2 = pulse_w[1];
  assign irq = irq_r;
  assign reg_rdata = rdata_r;

endmodule

// ==== tb/dpt_top_props.sv ====
// port-level properties of the dual pulse-width timer, bound to its top
`timescale 1ns/1ns
module dpt_top_props #(
  parameter int CNT_W = dpt_pkg::CNT_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [dpt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dpt_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [dpt_pkg::DATA_W-1:0] reg_rdata,
  input wire logic pulse_output_pin1,
  input wire logic pulse_output_pin2,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // a write to one word, a read of it in the next cycle
  sequence s_wr(a); reg_wr && reg_addr == a; endsequence
  sequence s_rd(a); reg_rd && reg_addr == a; endsequence
  property p_ctl_readback;
    s_wr(dpt_pkg::OFS_CONTROL) ##1 s_rd(dpt_pkg::OFS_CONTROL) |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 2)};
  endproperty
  a_ctl_readback: assert property (p_ctl_readback) else $error("control word read back wrong");
  property p_prd_readback;
    s_wr(dpt_pkg::OFS_PERIOD1) ##1 s_rd(dpt_pkg::OFS_PERIOD1) |=> reg_rdata == 16'($past(reg_wdata[CNT_W-1:0], 2));
  endproperty
  a_prd_readback: assert property (p_prd_readback) else $error("period word read back wrong");
  // read data stand one cycle only
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_zero_words;
    reg_rd && (reg_addr >= 4'h8 || reg_addr == dpt_pkg::OFS_IRQ_CLEAR) |=> reg_rdata == 16'h0000;
  endproperty
  a_zero_words: assert property (p_zero_words) else $error("unmapped or clear word not zero");
  ////////////////////////////////////////////////////////////////////////////
  // output enables low force both pins low two edges on
  property p_out_off;
    reg_wr && reg_addr == dpt_pkg::OFS_CONTROL && reg_wdata[7:6] == 2'h0 |-> ##2 !pulse_output_pin1 && !pulse_output_pin2;
  endproperty
  a_out_off: assert property (p_out_off) else $error("pin high with output disabled");
  property p_irq_off;
    reg_wr && reg_addr == dpt_pkg::OFS_IRQ_ENABLE && reg_wdata[1:0] == 2'h0 |-> ##2 !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt with all enables off");
  // high and low phases last at least one prescale tick of two clocks
  property p_high1;
    $rose(pulse_output_pin1) |-> pulse_output_pin1 [*2];
  endproperty
  a_high1: assert property (p_high1) else $error("pin1 pulse shorter than a tick");
  property p_high2;
    $rose(pulse_output_pin2) |-> pulse_output_pin2 [*2];
  endproperty
  a_high2: assert property (p_high2) else $error("pin2 pulse shorter than a tick");
  property p_low2;
    $fell(pulse_output_pin2) |-> !pulse_output_pin2 [*2];
  endproperty
  a_low2: assert property (p_low2) else $error("pin2 low phase shorter than a tick");
  property p_low1;
    $fell(pulse_output_pin1) |-> !pulse_output_pin1 [*2];
  endproperty
  a_low1: assert property (p_low1) else $error("pin1 low phase shorter than a tick");
endmodule
bind dpt_top dpt_top_props #(.CNT_W(CNT_W)) u_props (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pulse_output_pin1(pulse_output_pin1), .pulse_output_pin2(pulse_output_pin2), .irq(irq));

// ==== tb/dpt_load.sv ====
// load on one pulse pin: measures high time and period of each pulse
`timescale 1ns/1ns
module dpt_load (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin,
  output logic valid,
  output logic [15:0] hi,
  output logic [15:0] per,
  output logic [15:0] rises
);
  logic prev_r, seen_r; // last pin level, a rise seen
  logic [15:0] hi_r, per_r; // running counts of the pulse in progress
  ////////////////////////////////////////////////////////////////////////////
  // each rise reports the pulse before it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      {prev_r, seen_r, valid, hi_r, per_r, rises, hi, per} <= '0;
    end else begin
      prev_r <= pin;
      valid <= 1'b0;
      if (pin && !prev_r) begin
        valid <= seen_r; // first rise has no full period behind it
        hi <= hi_r;
        per <= per_r;
        rises <= rises + 16'h0001;
        seen_r <= 1'b1;
        hi_r <= 16'h0001;
        per_r <= 16'h0001;
      end else begin
        per_r <= per_r + 16'h0001;
        hi_r <= hi_r + {15'h0000, pin};
      end
    end
  end
endmodule

// ==== tb/dpt_top_tb.sv ====
// self-checking bench for the dual pulse-width timer
`timescale 1ns/1ns
module dpt_top_tb;
  logic clk_sys, reset, reg_wr, reg_rd, rd_d, v1, v2, pin1, pin2, irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, hi1, per1, hi2, per2, rise1, rise2;
  logic [15:0] exp_rd[$]; // expected read data, oldest first
  logic [31:0] exp_m1[$], exp_m2[$]; // expected {high, period} per load
  int fails, check_count;
  int ratio[4] = '{2, 8, 32, 64}; // divide of prescale codes 0..3
  dpt_top dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pulse_output_pin1(pin1), .pulse_output_pin2(pin2), .irq(irq));
  dpt_load ld1 (.clk_sys(clk_sys), .reset(reset), .pin(pin1), .valid(v1), .hi(hi1), .per(per1), .rises(rise1));
  dpt_load ld2 (.clk_sys(clk_sys), .reset(reset), .pin(pin2), .valid(v2), .hi(hi2), .per(per2), .rises(rise2));
  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  // monitor: read data in the cycle after the strobe, load reports
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_d) chk("rdata", reg_rdata, exp_rd.pop_front());
    if (v1 && exp_m1.size() > 0) chk("load1", {hi1, per1}, exp_m1.pop_front());
    if (v2 && exp_m2.size() > 0) chk("load2", {hi2, per2}, exp_m2.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus cycle; strobes stay as set until the next call
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_rd.push_back(e);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic cyc(input int n);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    repeat (n - 1) @(posedge clk_sys);
  endtask
  // bounded wait until every expectation is consumed
  task automatic wait_q();
    int n = 0;
    cyc(1);
    while (exp_rd.size() + exp_m1.size() + exp_m2.size() > 0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 4000) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic do_reset();
    cyc(1);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v;
    int r1, r2;
    fails = 0;
    check_count = 0;
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    v = 16'($urandom(32'h22e76c63));
    do_reset();
    // all words zero after reset, unmapped ones too
    for (int a = 0; a < 16; a++) rd(a[3:0], 16'h0000);
    // random write and read back, counters kept off
    repeat (8) begin
      v = 16'($urandom()) & 16'hffcf;
      wr(4'h0, v);
      rd(4'h0, {8'h00, v[7:0]});
      wr(4'h1, v);
      rd(4'h1, {6'h00, v[9:0]});
      wr(4'h5, v);
      rd(4'h5, 16'h0000);
      wr(4'h9, v);
      rd(4'h9, 16'h0000);
    end
    wait_q();
    // every prescale code on both channels at once
    for (int c = 0; c < 4; c++) begin
      r1 = ratio[c];
      r2 = ratio[3 - c];
      do_reset();
      wr(4'h1, 16'h0001);
      wr(4'h2, 16'h0003);
      wr(4'h3, 16'h0002);
      wr(4'h4, 16'h0005);
      wr(4'h0, {8'h00, 4'hf, 2'(3 - c), 2'(c)});
      repeat (2) exp_m1.push_back({16'(3 * r1), 16'(8 * r1)});
      repeat (2) exp_m2.push_back({16'(5 * r2), 16'(12 * r2)});
      wait_q();
    end
    // zero duty on 1, timer mode on 2; flags, mask and clear
    do_reset();
    wr(4'h4, 16'h0005);
    wr(4'h0, 16'h0070);
    cyc(40);
    chk("rise1", rise1, 32'h0);
    chk("rise2", rise2, 32'h0);
    wr(4'h0, 16'h0000);
    cyc(2);
    rd(4'h5, 16'h0003);
    wr(4'h7, 16'h0001);
    cyc(3);
    chk("irq", irq, 32'h1);
    wr(4'h5, 16'h0000);
    wr(4'h6, 16'h0001);
    cyc(3);
    chk("irq", irq, 32'h0);
    rd(4'h5, 16'h0002);
    wr(4'h7, 16'h0003);
    rd(4'h7, 16'h0003);
    cyc(3);
    chk("irq", irq, 32'h1);
    wr(4'h7, 16'h0000);
    cyc(3);
    chk("irq", irq, 32'h0);
    wr(4'h6, 16'h0002);
    cyc(20);
    rd(4'h5, 16'h0000);
    wait_q();
    // duty rewritten inside a pulse takes hold at the next wrap
    do_reset();
    wr(4'h1, 16'h0003);
    wr(4'h2, 16'h0004);
    wr(4'h0, 16'h0050);
    exp_m1.push_back({16'h0008, 16'h0020});
    wait_q();
    wr(4'h2, 16'h000a);
    exp_m1.push_back({16'h0008, 16'h0020});
    exp_m1.push_back({16'h0014, 16'h0020});
    wait_q();
    tally_and_finish();
  end
endmodule
